// ---- rtl/ifl_irq_logic.sv ----
// interrupt flag, enable and request logic behind an avalon-mm slave
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "ifl_regs.svh"
module ifl_irq_logic
	import ifl_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire ifl_events_t events,
	input  wire logic        event_ext_pin_async,
	input  wire logic [3:0]  upper_port_b_pins,
	input  wire ifl_cc_mode_t capcomp1_mode,
	input  wire ifl_cc_mode_t capcomp2_mode,
	input  wire logic        uart_rx_buffer_read,
	input  wire logic        uart_tx_buffer_write,
	input  wire logic        irq_taken,
	input  wire logic        return_from_irq_instruction,
	output logic             irq_request,
	output logic [12:0]      irq_vector
);
	logic [7:0]     core_interrupt_control, next_core;
	logic [7:0]     pie1, next_pie1, pir1, next_pir1;
	logic [7:0]     pie2, next_pie2, pir2, next_pir2;
	logic [7:0]     cfg, next_cfg;
	logic [1:0]     ext_sync, next_ext_sync;
	logic           ext_prev, next_ext_prev;
	logic [3:0]     pb_s1, next_pb_s1, pb_s2, next_pb_s2;
	logic [3:0]     pb_prev, next_pb_prev;
	logic           pb_primed, next_pb_primed;
	ifl_bus_state_t bus_state, next_bus_state;
	logic [31:0]    next_readdata;
	logic           irq_q, next_irq;
	logic           wr_acc;

	// one byte lane decodes write data for every register
	function automatic logic [7:0] ifl_merge(input logic [7:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		ifl_merge = be[0] ? wd[7:0] : old;
	endfunction : ifl_merge

	function automatic logic cc_hit(input ifl_cc_mode_t m,
		input logic cap, input logic cmp);
		case (m)
			IFL_CC_CAPTURE: cc_hit = cap;
			IFL_CC_COMPARE: cc_hit = cmp;
			default:        cc_hit = 1'b0;
		endcase
	endfunction : cc_hit

	// bus: read data latched a cycle early so it stands with the ack
	always_comb begin
		next_bus_state = bus_state;
		next_readdata  = avs_readdata;
		wr_acc         = 1'b0;
		case (bus_state)
			IFL_BUS_IDLE: begin
				if (avs_read || avs_write) begin
					next_bus_state = IFL_BUS_ACK;
				end
			end
			IFL_BUS_ACK: begin
				next_bus_state = IFL_BUS_HOLD;
				next_readdata  = 32'h0000_0000;
				if (avs_read) begin
					case (avs_address)
						`IFL_OFS_CORE:  next_readdata[7:0] = core_interrupt_control;
						`IFL_OFS_PENA1: next_readdata[7:0] = pie1;
						`IFL_OFS_PFLG1: next_readdata[7:0] = pir1;
						`IFL_OFS_PENA2: next_readdata[7:0] = pie2;
						`IFL_OFS_PFLG2: next_readdata[7:0] = pir2;
						`IFL_OFS_CFG:   next_readdata[7:0] = cfg;
						`IFL_OFS_STAT:  next_readdata[0]   = irq_q;
						default:        next_readdata      = 32'h0000_0000;
					endcase
				end
			end
			IFL_BUS_HOLD: begin
				wr_acc         = avs_write;
				next_bus_state = IFL_BUS_IDLE;
			end
			default:      next_bus_state = IFL_BUS_IDLE;
		endcase
	end

	// waitrequest drops in the hold cycle, where writes land
	assign avs_waitrequest = (bus_state != IFL_BUS_HOLD);

	// synchronisers and edge detection for pin sources
	always_comb begin
		next_ext_sync  = {ext_sync[0], event_ext_pin_async};
		next_ext_prev  = ext_sync[1];
		next_pb_s1     = upper_port_b_pins;
		next_pb_s2     = pb_s1;
		next_pb_prev   = pb_s2;
		next_pb_primed = 1'b1;
	end

	// flags and enables
	always_comb begin
		logic [7:0] pset1;
		logic [7:0] pset2;
		logic [7:0] cset;
		logic       ext_rise;
		logic       pb_change;
		logic [7:0] wcore;
		pset1     = 8'h00;
		pset2     = 8'h00;
		cset      = 8'h00;
		ext_rise  = ext_sync[1] & ~ext_prev;
		pb_change = pb_primed & (pb_s2 != pb_prev);
		next_core = core_interrupt_control;
		next_pie1 = pie1;
		next_pie2 = pie2;
		next_pir1 = pir1;
		next_pir2 = pir2;
		next_cfg  = cfg;
		next_irq  = 1'b0;
		wcore     = core_interrupt_control;

		if (wr_acc) begin
			case (avs_address)
				`IFL_OFS_CORE: begin
					wcore = ifl_merge(core_interrupt_control, avs_writedata,
						avs_byteenable);
				end
				`IFL_OFS_PENA1: next_pie1 = ifl_merge(pie1, avs_writedata,
					avs_byteenable);
				`IFL_OFS_PFLG1: next_pir1 = ifl_merge(pir1, avs_writedata,
					avs_byteenable);
				`IFL_OFS_PENA2: next_pie2 = ifl_merge(pie2, avs_writedata,
					avs_byteenable);
				`IFL_OFS_PFLG2: next_pir2 = ifl_merge(pir2, avs_writedata,
					avs_byteenable);
				`IFL_OFS_CFG:   next_cfg = ifl_merge(cfg, avs_writedata,
					avs_byteenable);
				default: ;
			endcase
		end
		if (return_from_irq_instruction) begin
			wcore[`IFL_BIT_GEN] = 1'b1;
		end
		if (irq_taken) begin
			wcore[`IFL_BIT_GEN] = 1'b0;
		end

		// events OR in after the software write, so a set beats a clear
		cset[`IFL_BIT_T0F] = events.timer0_overflow;
		cset[`IFL_BIT_EXF] = ext_rise | events.ext_pin;
		cset[`IFL_BIT_PCF] = pb_change;
		next_core = wcore | cset;
		if (!cfg[`IFL_CFG_HAS_EXT]) begin
			next_core[`IFL_BIT_EXE] = 1'b0;
			next_core[`IFL_BIT_EXF] = 1'b0;
		end
		if (!cfg[`IFL_CFG_HAS_PC]) begin
			next_core[`IFL_BIT_PCE] = 1'b0;
			next_core[`IFL_BIT_PCF] = 1'b0;
		end

		pset1[`IFL_P1_T1OV] = events.timer1_overflow;
		pset1[`IFL_P1_T2M]  = events.timer2_match;
		pset1[`IFL_P1_CC1]  = cc_hit(capcomp1_mode, events.capcomp1_capture,
			events.capcomp1_compare);
		pset1[`IFL_P1_ADC]  = events.converter_done;
		pset1[`IFL_P1_PSP]  = events.parallel_port_rw;
		pset2[`IFL_P2_CC2]  = cc_hit(capcomp2_mode, events.capcomp2_capture,
			events.capcomp2_compare);
		pset2[`IFL_P2_SLT]  = events.converter_done | events.slope_trip;
		pset2[`IFL_P2_SLO]  = events.slope_timer_overflow;
		pset2[`IFL_P2_NV]   = events.nv_write_done;
		pset2[`IFL_P2_DSP]  = events.display_event;
		pset2[`IFL_P2_CMP]  = events.comparator_change;
		next_pir1 = next_pir1 | pset1;
		next_pir2 = next_pir2 | pset2;

		// status-following flags: hardware owns them, writes are ignored
		next_pir1[`IFL_P1_SSP] = events.sync_serial_done;
		next_pir1[`IFL_P1_RX] = events.uart_rx_full & ~uart_rx_buffer_read;
		next_pir1[`IFL_P1_TX] = events.uart_tx_empty & ~uart_tx_buffer_write;

		// request from registered state
		if (core_interrupt_control[`IFL_BIT_GEN]) begin
			next_irq = |(core_interrupt_control[5:3]
				& core_interrupt_control[2:0]);
			if (cfg[`IFL_CFG_SINGLE]) begin
				next_irq = next_irq | (core_interrupt_control[`IFL_BIT_PGATE]
					& pir1[0]);
			end else if (core_interrupt_control[`IFL_BIT_PGATE]) begin
				next_irq = next_irq | (|(pie1 & pir1)) | (|(pie2 & pir2));
			end
		end
	end

	assign irq_request = irq_q;
	assign irq_vector  = `IFL_VECTOR;

	always_ff @(posedge clock) begin
		if (srst) begin
			bus_state              <= IFL_BUS_IDLE;
			avs_readdata           <= 32'h0000_0000;
			core_interrupt_control <= `IFL_RST_BYTE;
			pie1                   <= `IFL_RST_BYTE;
			pie2                   <= `IFL_RST_BYTE;
			pir1                   <= `IFL_RST_BYTE;
			pir2                   <= `IFL_RST_BYTE;
			cfg                    <= `IFL_RST_CFG;
			ext_sync               <= 2'h0;
			ext_prev               <= 1'b0;
			pb_s1                  <= 4'h0;
			pb_s2                  <= 4'h0;
			pb_prev                <= 4'h0;
			pb_primed              <= 1'b0;
			irq_q                  <= 1'b0;
		end else begin
			bus_state              <= next_bus_state;
			avs_readdata           <= next_readdata;
			core_interrupt_control <= next_core;
			pie1                   <= next_pie1;
			pie2                   <= next_pie2;
			pir1                   <= next_pir1;
			pir2                   <= next_pir2;
			cfg                    <= next_cfg;
			ext_sync               <= next_ext_sync;
			ext_prev               <= next_ext_prev;
			pb_s1                  <= next_pb_s1;
			pb_s2                  <= next_pb_s2;
			pb_prev                <= next_pb_prev;
			pb_primed              <= next_pb_primed;
			irq_q                  <= next_irq;
		end
	end
endmodule : ifl_irq_logic

// ---- rtl/ifl_regs.svh ----
// register offsets, field positions and reset values of the interrupt logic
`ifndef IFL_REGS_SVH
`define IFL_REGS_SVH
`define IFL_OFS_CORE      4'h0
`define IFL_OFS_PENA1     4'h1
`define IFL_OFS_PFLG1     4'h2
`define IFL_OFS_PENA2     4'h3
`define IFL_OFS_PFLG2     4'h4
`define IFL_OFS_CFG       4'h5
`define IFL_OFS_STAT      4'h6
`define IFL_RST_BYTE      8'h00
`define IFL_RST_CFG       8'h03
`define IFL_BIT_GEN       7
`define IFL_BIT_PGATE     6
`define IFL_BIT_T0E       5
`define IFL_BIT_EXE       4
`define IFL_BIT_PCE       3
`define IFL_BIT_T0F       2
`define IFL_BIT_EXF       1
`define IFL_BIT_PCF       0
`define IFL_P1_T1OV       0
`define IFL_P1_T2M        1
`define IFL_P1_CC1        2
`define IFL_P1_SSP        3
`define IFL_P1_RX         4
`define IFL_P1_TX         5
`define IFL_P1_ADC        6
`define IFL_P1_PSP        7
`define IFL_P2_CC2        0
`define IFL_P2_SLT        1
`define IFL_P2_SLO        2
`define IFL_P2_NV         3
`define IFL_P2_DSP        4
`define IFL_P2_CMP        5
`define IFL_CFG_HAS_EXT   0
`define IFL_CFG_HAS_PC    1
`define IFL_CFG_SINGLE    2
`define IFL_VECTOR        13'h0004
`endif

// ---- rtl/ifl_pkg.sv ----
// types shared by the interrupt flag and enable logic
package ifl_pkg;
	typedef struct packed {
		logic timer0_overflow;
		logic ext_pin;
		logic [3:0] upper_port_b_pins;
		logic timer1_overflow;
		logic timer2_match;
		logic capcomp1_capture;
		logic capcomp1_compare;
		logic capcomp2_capture;
		logic capcomp2_compare;
		logic sync_serial_done;
		logic uart_rx_full;
		logic uart_tx_empty;
		logic converter_done;
		logic slope_trip;
		logic slope_timer_overflow;
		logic parallel_port_rw;
		logic nv_write_done;
		logic display_event;
		logic comparator_change;
	} ifl_events_t;
	typedef enum logic [1:0] {
		IFL_CC_CAPTURE = 2'h0,
		IFL_CC_COMPARE = 2'h1,
		IFL_CC_PWM     = 2'h2
	} ifl_cc_mode_t;
	typedef enum logic [2:0] {
		IFL_BUS_IDLE = 3'h1,
		IFL_BUS_ACK  = 3'h2,
		IFL_BUS_HOLD = 3'h4
	} ifl_bus_state_t;
endpackage : ifl_pkg

// ---- dv/ifl_irq_props.sv ----
// port assertions for the interrupt flag and enable logic
`timescale 1ns/1ns
module ifl_irq_props (
	input wire logic        clock,
	input wire logic        srst,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        irq_taken,
	input wire logic        irq_request,
	input wire logic [12:0] irq_vector
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// idle, ack, hold: the slave never acks two cycles running
	sequence gap_s;
		avs_waitrequest [*2];
	endsequence
	vector_fixed_a: assert property (irq_vector == 13'h0004)
		else $error("vector not fixed");
	upper_zero_a: assert property (avs_readdata[31:8] == 24'h0)
		else $error("readdata upper bits set");
	reset_clear_a: assert property ($fell(srst) |->
		avs_readdata == 32'h0 && !irq_request) else $error("not cleared");
	idle_wait_a: assert property (!avs_read && !avs_write |=>
		avs_waitrequest) else $error("ack without request");
	ack_gap_a: assert property (!avs_waitrequest |=> gap_s)
		else $error("ack spacing short");
	ack_cause_a: assert property ($fell(avs_waitrequest) |->
		$past(avs_read || avs_write)) else $error("ack cause missing");
	unmapped_zero_a: assert property (!avs_waitrequest && avs_read &&
		avs_address > 4'h6 |=> avs_readdata == 32'h0) else $error("nonzero");
	taken_block_a: assert property (irq_taken && !avs_write |->
		##2 !irq_request) else $error("request after take");
endmodule : ifl_irq_props
bind ifl_irq_logic ifl_irq_props u_props (.clock, .srst, .avs_address,
	.avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .irq_taken,
	.irq_request, .irq_vector);

// ---- dv/ifl_core_model.sv ----
// processor core model: takes a request, returns on command
`timescale 1ns/1ns
module ifl_core_model (
	input  wire logic clock,
	input  wire logic srst,
	input  wire logic irq_request,
	input  wire logic ret_req,
	output logic      irq_taken,
	output logic      return_from_irq_instruction
);
	logic in_svc;
	logic next_in_svc;
	always_comb begin
		next_in_svc = in_svc;
		if (irq_request && !in_svc) next_in_svc = 1'b1;
		if (ret_req) next_in_svc = 1'b0;
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			in_svc <= 1'b0;
			irq_taken <= 1'b0;
			return_from_irq_instruction <= 1'b0;
		end else begin
			in_svc <= next_in_svc;
			irq_taken <= irq_request && !in_svc;
			return_from_irq_instruction <= ret_req && in_svc;
		end
	end
endmodule : ifl_core_model

// ---- dv/tb.sv ----
// register-level bench of the interrupt flag and enable logic
`timescale 1ns/1ns
module tb;
	import ifl_pkg::*;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	ifl_events_t ev = '0;
	logic        ext_pin = 1'b0;
	logic [3:0]  upb = 4'h0;
	ifl_cc_mode_t cc1 = IFL_CC_CAPTURE;
	logic        rx_rd = 1'b0;
	logic        tx_wr = 1'b0;
	logic        ret_req = 1'b0;
	logic        irq_taken;
	logic        return_from_irq_instruction;
	logic        irq_request;
	int          fails = 0;
	int          n_compared = 0;
	int          k;
	logic [7:0]  q;
	int          bits [8] = '{3, 2, 1, 0, 4, 10, 14, 13};
	int          offs [8] = '{2, 4, 4, 4, 4, 4, 2, 2};
	logic [7:0]  exps [8] = '{8'h80, 8'h08, 8'h10, 8'h20, 8'h04, 8'h01,
		8'h02, 8'h04};
	always #20 clock = ~clock;
	ifl_irq_logic dut (.clock, .srst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.events(ev), .event_ext_pin_async(ext_pin), .upper_port_b_pins(upb),
		.capcomp1_mode(cc1), .capcomp2_mode(IFL_CC_COMPARE),
		.uart_rx_buffer_read(rx_rd), .uart_tx_buffer_write(tx_wr),
		.irq_taken, .return_from_irq_instruction, .irq_request,
		.irq_vector());
	ifl_core_model u_core (.clock, .srst, .irq_request, .ret_req,
		.irq_taken, .return_from_irq_instruction);
	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// request held until the edge that samples waitrequest low
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] be);
		int i;
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 20);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			fails++;
			complete_run;
		end
		@(posedge clock);
	endtask : bus
	task wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask : wr
	task rd(input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, 4'h1);
		chk($sformatf("reg%0d", a), q, e);
	endtask : rd
	task pulse(input int b);
		ev[b] <= 1'b1;
		@(posedge clock);
		ev[b] <= 1'b0;
		@(posedge clock);
	endtask : pulse
	// n above 4 waits for the level, otherwise settles n cycles first
	task irq_is(input logic v, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(negedge clock);
			if (irq_request === v && n > 4) break;
		end
		chk("irq", {7'h0, irq_request}, {7'h0, v});
		@(posedge clock);
	endtask : irq_is
	task ret_pulse;
		ret_req <= 1'b1;
		@(posedge clock);
		ret_req <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : ret_pulse
	initial begin
		repeat (5) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		for (k = 0; k < 5; k++) rd(k[3:0], 8'h00);
		rd(4'h5, 8'h03);
		rd(4'h7, 8'h00);
		$display("reset test done");
		wr(4'h0, 8'h3f);
		rd(4'h0, 8'h3f);
		irq_is(1'b0, 4);
		wr(4'h0, 8'h00);
		pulse(21);
		rd(4'h0, 8'h04);
		wr(4'h0, 8'ha4);
		irq_is(1'b1, 20);
		rd(4'h0, 8'h24);
		wr(4'h0, 8'h20);
		ret_pulse;
		rd(4'h0, 8'ha0);
		irq_is(1'b0, 4);
		$display("core test done");
		wr(4'h1, 8'h01);
		pulse(15);
		rd(4'h2, 8'h01);
		irq_is(1'b0, 4);
		wr(4'h0, 8'hc0);
		irq_is(1'b1, 20);
		wr(4'h2, 8'h00);
		ret_pulse;
		wr(4'h0, 8'h00);
		$display("gate test done");
		for (k = 0; k < 8; k++) begin
			pulse(bits[k]);
			rd(offs[k][3:0], exps[k]);
			wr(offs[k][3:0], 8'h00);
		end
		cc1 <= IFL_CC_PWM;
		pulse(13);
		rd(4'h2, 8'h00);
		pulse(6);
		rd(4'h2, 8'h40);
		rd(4'h4, 8'h02);
		wr(4'h2, 8'h00);
		ev[9:7] <= 3'h7;
		rd(4'h2, 8'h38);
		wr(4'h2, 8'h00);
		rd(4'h2, 8'h38);
		ev[9:7] <= 3'h0;
		rx_rd <= 1'b1;
		tx_wr <= 1'b1;
		@(posedge clock);
		rx_rd <= 1'b0;
		tx_wr <= 1'b0;
		rd(4'h2, 8'h00);
		$display("flag test done");
		ext_pin <= 1'b1;
		upb <= 4'h8;
		repeat (6) @(posedge clock);
		rd(4'h0, 8'h03);
		wr(4'h0, 8'h00);
		rd(4'h0, 8'h00);
		wr(4'h1, 8'hff);
		bus(1'b1, 4'h1, 8'h00, 4'h0);
		rd(4'h1, 8'hff);
		wr(4'h3, 8'h3f);
		rd(4'h3, 8'h3f);
		$display("enable test done");
		complete_run;
	end
endmodule : tb
